// [logic/spf_pkg.sv]
/*
  Shared constants, types and helpers of the serial port with line format
  and protocol selection. Assumes a 250 MHz system clock.
*/
package spf_pkg;
  localparam int unsigned CLK_HZ         = 250_000_000;
  localparam int unsigned IDLE_TIMEOUT_S = 10;
  localparam logic [31:0] IDLE_CYCLES    = 32'(64'(IDLE_TIMEOUT_S) * 64'(CLK_HZ));
  localparam int unsigned OVERSAMPLE     = 16;

  // Line format code fields and values after power-up
  localparam int         FMT_DATA7   = 7;
  localparam int         FMT_PAR_EN  = 6;
  localparam int         FMT_PAR_ODD = 5;
  localparam int         FMT_STOP2   = 4;
  localparam logic [7:0] FMT_RESET   = 8'h06;
  localparam logic [7:0] PORT_ONE    = 8'h01;

  // Protocol select codes
  localparam logic [2:0] SEL_AUTO   = 3'h0;
  localparam logic [2:0] SEL_NONE   = 3'h1;
  localparam logic [2:0] SEL_NATIVE = 3'h2;
  localparam logic [2:0] SEL_ASCII  = 3'h3;
  localparam logic [2:0] SEL_RTU    = 3'h4;
  localparam logic [2:0] SEL_VENDOR = 3'h5;

  // Frame start characters and integrity check constants
  localparam logic [7:0]  START_ASCII  = 8'h3A;
  localparam logic [7:0]  START_VENDOR = 8'h40;
  localparam logic [7:0]  START_NATIVE = 8'h2A;
  localparam logic [15:0] CRC_POLY     = 16'hA001;
  localparam logic [15:0] CRC_INIT     = 16'hFFFF;

  localparam int unsigned RXBUF_DEPTH = 256;

  // Register byte addresses
  localparam logic [7:0] ADDR_FORMAT = 8'h00;
  localparam logic [7:0] ADDR_PROTO  = 8'h04;
  localparam logic [7:0] ADDR_RXDATA = 8'h08;
  localparam logic [7:0] ADDR_RXSTAT = 8'h0C;
  localparam logic [7:0] ADDR_TX     = 8'h10;
  localparam logic [7:0] ADDR_CHECK  = 8'h14;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    MODE_AUTO   = 3'b000,
    MODE_NATIVE = 3'b001,
    MODE_ASCII  = 3'b011,
    MODE_RTU    = 3'b010,
    MODE_VENDOR = 3'b110,
    MODE_NONE   = 3'b111
  } spf_mode_e;

  typedef struct packed {
    logic data7;
    logic stop2;
    logic par_en;
    logic par_odd;
  } spf_frame_s;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } spf_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } spf_axi_rsp_s;

  localparam int unsigned BAUD_TBL [16] = '{2400, 2400, 4800, 9600, 19200, 31250, 38400, 57600,
                                             100000, 115200, 230400, 110, 150, 300, 600, 1200};

  // Clock cycles per oversample tick, rounded to nearest
  function automatic logic [17:0] spf_divisor(input logic [3:0] code);
    int unsigned b;
    b = BAUD_TBL[code];
    return 18'((CLK_HZ + (OVERSAMPLE / 2) * b) / (OVERSAMPLE * b));
  endfunction
endpackage

// [logic/spf_rx.sv]
/*
  Asynchronous character receiver, 16 ticks per bit.
  Assumes a clean, synchronised line level and a one-cycle tick pulse.
*/
`timescale 1ns/1ns
module spf_rx (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Timing and line
  input  wire logic        tick,
  input  wire logic        rxd,
  input  spf_pkg::spf_frame_s cfg,
  // Received character
  output logic             valid,
  output logic [7:0]       data,
  output logic             perr,
  output logic             ferr
);
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b011, RX_PAR = 3'b010, RX_STOP = 3'b110
  } spf_rx_e;

  spf_rx_e    st_q;
  logic [3:0] cnt_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic       par_q;
  logic       fe_q;
  logic       stop_q;

  wire       mid   = tick && (cnt_q == 4'hF);
  wire [2:0] last  = cfg.data7 ? 3'h6 : 3'h7;
  wire [7:0] dword = cfg.data7 ? {1'b0, sh_q[7:1]} : sh_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= RX_IDLE;
      cnt_q <= 4'h0;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      par_q <= 1'b0;
      fe_q <= 1'b0;
      stop_q <= 1'b0;
      valid <= 1'b0;
      data <= 8'h00;
      perr <= 1'b0;
      ferr <= 1'b0;
    end else begin
      valid <= 1'b0;
      if (tick) begin
        cnt_q <= cnt_q + 4'h1;
      end
      unique case (st_q)
        RX_IDLE: begin
          cnt_q <= 4'h0;
          if (!rxd) begin
            st_q <= RX_START;
          end
        end
        RX_START: begin
          if (tick && cnt_q == 4'h7) begin
            cnt_q <= 4'h0;
            bit_q <= 3'h0;
            fe_q <= 1'b0;
            stop_q <= 1'b0;
            st_q <= rxd ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (mid) begin
            sh_q <= {rxd, sh_q[7:1]};
            bit_q <= bit_q + 3'h1;
            if (bit_q == last) begin
              st_q <= cfg.par_en ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (mid) begin
            par_q <= rxd;
            st_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (mid) begin
            fe_q <= fe_q | !rxd;
            if (cfg.stop2 && !stop_q) begin
              stop_q <= 1'b1;
            end else begin
              valid <= 1'b1;
              data <= dword;
              perr <= cfg.par_en && ((^dword ^ par_q) != cfg.par_odd);
              ferr <= fe_q | !rxd;
              st_q <= RX_IDLE;
            end
          end
        end
        default: st_q <= RX_IDLE;
      endcase
    end
  end
endmodule

// [logic/spf_top.sv]
/*
  Serial port with programmable line format and host protocol mode,
  reached over AXI4-Lite. Assumes a half-duplex bus transceiver on the
  pins, por high only on power-up, srst as the software reset.
*/
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
module spf_top #(
  parameter logic [31:0] IDLE_CYCLES = spf_pkg::IDLE_CYCLES
) (
  // Clock and resets
  input  wire logic           clk,
  input  wire logic           srst,
  input  wire logic           por,
  // Register bus
  input  spf_pkg::spf_axi_req_s axi_req,
  output spf_pkg::spf_axi_rsp_s axi_rsp,
  // Bus transceiver
  input  wire logic           rs485_rxd,
  output logic                rs485_txd,
  output logic                rs485_de,
  output logic                rs485_re_n,
  // Board strap
  input  wire logic           halt_jumper
);
  wire rst = srst | por;

  // Pin synchronisers: bit 1 jumper, bit 0 line
  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [1:0] s3_q;
  logic       rxd_q;
  always_ff @(posedge clk) begin
    s1_q <= {halt_jumper, rs485_rxd};
    s2_q <= s1_q;
    s3_q <= s2_q;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      rxd_q <= 1'b1;
    end else if (s2_q[0] == s3_q[0]) begin
      rxd_q <= s3_q[0];
    end
  end

  // Jumper caught once, just after power-up
  logic cap_q;
  logic halt_q;
  always_ff @(posedge clk) begin
    if (por) begin
      cap_q <= 1'b1;
      halt_q <= 1'b0;
    end else if (cap_q) begin
      cap_q <= 1'b0;
      halt_q <= s2_q[1] & s3_q[1];
    end
  end

  // AXI4-Lite slave
  logic        aw_q;
  logic        w_q;
  logic        bvalid_q;
  logic        rvalid_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  assign axi_rsp.awready = !aw_q && !bvalid_q;
  assign axi_rsp.wready  = !w_q && !bvalid_q;
  assign axi_rsp.arready = !rvalid_q;
  assign axi_rsp.bvalid  = bvalid_q;
  assign axi_rsp.bresp   = bresp_q;
  assign axi_rsp.rvalid  = rvalid_q;
  assign axi_rsp.rresp   = rresp_q;
  assign axi_rsp.rdata   = rdata_q;

  wire aw_take = axi_req.awvalid && axi_rsp.awready;
  wire w_take  = axi_req.wvalid && axi_rsp.wready;
  wire ar_take = axi_req.arvalid && axi_rsp.arready;
  wire do_wr   = aw_q && w_q && !bvalid_q;

  wire wr_fmt   = do_wr && awaddr_q == spf_pkg::ADDR_FORMAT;
  wire wr_proto = do_wr && awaddr_q == spf_pkg::ADDR_PROTO;
  wire wr_stat  = do_wr && awaddr_q == spf_pkg::ADDR_RXSTAT;
  wire wr_tx    = do_wr && awaddr_q == spf_pkg::ADDR_TX;
  wire wr_check = do_wr && awaddr_q == spf_pkg::ADDR_CHECK;
  wire wr_hit   = wr_fmt | wr_proto | wr_stat | wr_tx | wr_check
                | (do_wr && awaddr_q == spf_pkg::ADDR_RXDATA);
  wire rd_data  = ar_take && axi_req.araddr == spf_pkg::ADDR_RXDATA;
  wire soft_ok  = !halt_q && !cap_q;

  // Line format, loaded with FMT_RESET only by power-up
  logic [7:0] fmt_q;
  wire fmt_ok = wr_fmt && (&wstrb_q[1:0]) && wdata_q[15:8] == spf_pkg::PORT_ONE && soft_ok;
  always_ff @(posedge clk) begin
    if (por) begin
      fmt_q <= spf_pkg::FMT_RESET;
    end else if (fmt_ok) begin
      fmt_q <= wdata_q[7:0];
    end
  end

  spf_pkg::spf_frame_s cfg;
  assign cfg = {fmt_q[spf_pkg::FMT_DATA7], fmt_q[spf_pkg::FMT_STOP2],
                fmt_q[spf_pkg::FMT_PAR_EN], fmt_q[spf_pkg::FMT_PAR_ODD]};

  // Oversample tick from the baud nibble
  logic [17:0] div_q;
  wire [17:0] div_top = spf_pkg::spf_divisor(fmt_q[3:0]);
  wire        tick    = div_q == 18'h0;
  always_ff @(posedge clk) begin
    if (rst || tick) begin
      div_q <= div_top - 18'h1;
    end else begin
      div_q <= div_q - 18'h1;
    end
  end

  // Character engines
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       rx_perr;
  logic       rx_ferr;
  logic       tx_busy;
  logic       hold_q;
  logic [7:0] hold_data_q;
  wire        tx_start = hold_q && !tx_busy;

  spf_rx u_rx (
    .clk   (clk),
    .srst  (rst),
    .tick  (tick),
    .rxd   (rxd_q),
    .cfg   (cfg),
    .valid (rx_valid),
    .data  (rx_data),
    .perr  (rx_perr),
    .ferr  (rx_ferr)
  );

  spf_tx u_tx (
    .clk   (clk),
    .srst  (rst),
    .tick  (tick),
    .cfg   (cfg),
    .start (tx_start),
    .data  (hold_data_q),
    .busy  (tx_busy),
    .txd   (rs485_txd)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      hold_q <= 1'b0;
      hold_data_q <= 8'h00;
    end else if (wr_tx && wstrb_q[0] && !hold_q) begin
      hold_q <= 1'b1;
      hold_data_q <= wdata_q[7:0];
    end else if (tx_start) begin
      hold_q <= 1'b0;
    end
  end

  // Driver held across queued characters, dropped after last stop
  assign rs485_de   = tx_busy | hold_q;
  assign rs485_re_n = tx_busy | hold_q;

  // Receive ring: every byte stored, oldest overwritten
  logic [9:0] mem_q [spf_pkg::RXBUF_DEPTH];
  logic [7:0] wp_q;
  logic [7:0] rp_q;
  logic [8:0] cnt_q;
  logic       ovf_q;
  wire        full  = cnt_q == 9'(spf_pkg::RXBUF_DEPTH);
  wire        empty = cnt_q == 9'h0;
  wire        pop   = rd_data && !empty;
  always_ff @(posedge clk) begin
    if (rx_valid) begin
      mem_q[wp_q] <= {rx_ferr, rx_perr, rx_data};
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= 8'h00;
      rp_q <= 8'h00;
      cnt_q <= 9'h0;
      ovf_q <= 1'b0;
    end else begin
      if (rx_valid) begin
        wp_q <= wp_q + 8'h01;
      end
      if (pop || (rx_valid && full)) begin
        rp_q <= rp_q + 8'h01;
      end
      if (rx_valid && !pop && !full) begin
        cnt_q <= cnt_q + 9'h1;
      end else if (pop && !rx_valid) begin
        cnt_q <= cnt_q - 9'h1;
      end
      if (rx_valid && full && !pop) begin
        ovf_q <= 1'b1;
      end else if (wr_stat && wstrb_q[1] && wdata_q[9]) begin
        ovf_q <= 1'b0;
      end
    end
  end

  // Protocol mode
  spf_pkg::spf_mode_e mode_q;
  spf_pkg::spf_mode_e mode_d;
  spf_pkg::spf_mode_e cls;
  logic [2:0]  sel_q;
  logic [31:0] idle_q;
  logic        foreign_q;

  wire is_ascii  = rx_data == spf_pkg::START_ASCII;
  wire is_native = rx_data == spf_pkg::START_NATIVE;
  wire is_vendor = rx_data == spf_pkg::START_VENDOR;
  wire is_text   = is_ascii | is_native | is_vendor;
  wire rx_good   = rx_valid && !rx_perr && !rx_ferr;
  assign cls = is_ascii ? spf_pkg::MODE_ASCII : is_native ? spf_pkg::MODE_NATIVE
             : is_vendor ? spf_pkg::MODE_VENDOR : spf_pkg::MODE_RTU;

  wire text_q  = mode_q == spf_pkg::MODE_ASCII || mode_q == spf_pkg::MODE_NATIVE
              || mode_q == spf_pkg::MODE_VENDOR;
  wire own_q   = (mode_q == spf_pkg::MODE_ASCII && is_ascii) || (mode_q == spf_pkg::MODE_NATIVE && is_native)
              || (mode_q == spf_pkg::MODE_VENDOR && is_vendor);
  wire foreign = rx_valid && text_q && is_text && !own_q;
  wire locked  = sel_q == spf_pkg::SEL_AUTO && mode_q != spf_pkg::MODE_AUTO && mode_q != spf_pkg::MODE_NONE;
  wire idle_hit = locked && !rx_valid && idle_q == IDLE_CYCLES - 32'h1;

  always_comb begin
    mode_d = mode_q;
    unique case (sel_q)
      spf_pkg::SEL_NONE:   mode_d = spf_pkg::MODE_NONE;
      spf_pkg::SEL_NATIVE: mode_d = spf_pkg::MODE_NATIVE;
      spf_pkg::SEL_ASCII:  mode_d = spf_pkg::MODE_ASCII;
      spf_pkg::SEL_RTU:    mode_d = spf_pkg::MODE_RTU;
      spf_pkg::SEL_VENDOR: mode_d = spf_pkg::MODE_VENDOR;
      default: begin
        if (mode_q == spf_pkg::MODE_NONE) begin
          mode_d = spf_pkg::MODE_AUTO;
        end else if (mode_q == spf_pkg::MODE_AUTO && rx_good) begin
          mode_d = cls;
        end else if (idle_hit) begin
          mode_d = spf_pkg::MODE_AUTO;
        end
      end
    endcase
  end

  wire [2:0] sel_w = (wdata_q[2:0] > spf_pkg::SEL_VENDOR) ? spf_pkg::SEL_AUTO : wdata_q[2:0];
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= spf_pkg::MODE_AUTO;
      sel_q <= spf_pkg::SEL_AUTO;
      idle_q <= 32'h0;
      foreign_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      if (wr_proto && wstrb_q[0] && soft_ok) begin
        sel_q <= sel_w;
      end
      idle_q <= (!locked || rx_valid || idle_hit) ? 32'h0 : idle_q + 32'h1;
      if (foreign) begin
        foreign_q <= 1'b1;
      end else if (wr_proto && wstrb_q[1] && wdata_q[8]) begin
        foreign_q <= 1'b0;
      end
    end
  end

  // Integrity accumulators over bytes accepted by the active protocol
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ spf_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  logic [15:0] crc_q;
  logic [7:0]  lrc_q;
  logic [7:0]  fcs_q;
  wire acc_en  = rx_valid && !foreign && mode_d != spf_pkg::MODE_AUTO && mode_d != spf_pkg::MODE_NONE;
  wire restart = acc_en && ((mode_d == spf_pkg::MODE_ASCII && is_ascii) || (mode_d == spf_pkg::MODE_NATIVE && is_native)
              || (mode_d == spf_pkg::MODE_VENDOR && is_vendor));
  wire [15:0] crc_base = restart ? spf_pkg::CRC_INIT : crc_q;
  wire [7:0]  lrc_base = restart ? 8'h00 : lrc_q;
  wire [7:0]  fcs_base = restart ? 8'h00 : fcs_q;
  always_ff @(posedge clk) begin
    if (rst || wr_check) begin
      crc_q <= spf_pkg::CRC_INIT;
      lrc_q <= 8'h00;
      fcs_q <= 8'h00;
    end else if (acc_en) begin
      crc_q <= crc_step(crc_base, rx_data);
      lrc_q <= lrc_base + rx_data;
      fcs_q <= fcs_base ^ rx_data;
    end
  end

  // Read selection
  wire [7:0]  ra     = axi_req.araddr;
  wire [31:0] rd_fmt = {23'h0, halt_q, fmt_q};
  wire [31:0] rd_pro = {23'h0, foreign_q, 1'b0, mode_q, 1'b0, sel_q};
  wire [31:0] rd_rxd = {21'h0, !empty, mem_q[rp_q]};
  wire [31:0] rd_sta = {22'h0, ovf_q, cnt_q};
  wire [31:0] rd_txs = {30'h0, hold_q, tx_busy};
  wire [31:0] rd_chk = {fcs_q, lrc_q, crc_q};
  wire rd_hit = ra == spf_pkg::ADDR_FORMAT || ra == spf_pkg::ADDR_PROTO || ra == spf_pkg::ADDR_RXDATA
             || ra == spf_pkg::ADDR_RXSTAT || ra == spf_pkg::ADDR_TX || ra == spf_pkg::ADDR_CHECK;
  wire [31:0] rd_mux = (ra == spf_pkg::ADDR_FORMAT) ? rd_fmt
                     : (ra == spf_pkg::ADDR_PROTO)  ? rd_pro
                     : (ra == spf_pkg::ADDR_RXDATA) ? rd_rxd
                     : (ra == spf_pkg::ADDR_RXSTAT) ? rd_sta
                     : (ra == spf_pkg::ADDR_TX)     ? rd_txs
                     : (ra == spf_pkg::ADDR_CHECK)  ? rd_chk : 32'h0;

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bresp_q <= spf_pkg::RESP_OKAY;
      rresp_q <= spf_pkg::RESP_OKAY;
      rdata_q <= 32'h0;
    end else begin
      if (aw_take) begin
        aw_q <= 1'b1;
        awaddr_q <= axi_req.awaddr;
      end else if (do_wr) begin
        aw_q <= 1'b0;
      end
      if (w_take) begin
        w_q <= 1'b1;
        wdata_q <= axi_req.wdata;
        wstrb_q <= axi_req.wstrb;
      end else if (do_wr) begin
        w_q <= 1'b0;
      end
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? spf_pkg::RESP_OKAY : spf_pkg::RESP_DECERR;
      end else if (axi_req.bready) begin
        bvalid_q <= 1'b0;
      end
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_hit ? spf_pkg::RESP_OKAY : spf_pkg::RESP_DECERR;
      end else if (axi_req.rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
endmodule

// [logic/spf_tx.sv]
/*
  Asynchronous character transmitter, 16 ticks per bit.
  Assumes start is a one-cycle pulse given only while busy is low.
*/
`timescale 1ns/1ns
module spf_tx (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Timing and format
  input  wire logic        tick,
  input  spf_pkg::spf_frame_s cfg,
  // Character in
  input  wire logic        start,
  input  wire logic [7:0]  data,
  output logic             busy,
  // Line
  output logic             txd
);
  logic [11:0] sh_q;
  logic [3:0]  n_q;
  logic [3:0]  cnt_q;
  logic [11:0] fr_d;
  logic [3:0]  len_d;

  wire [3:0] nd  = cfg.data7 ? 4'd7 : 4'd8;
  wire [7:0] msk = cfg.data7 ? 8'h7F : 8'hFF;
  wire       par = ^(data & msk) ^ cfg.par_odd;

  // Start, data LSB first, optional parity, stop bits
  always_comb begin
    fr_d = 12'hFFF;
    fr_d[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < nd) fr_d[i + 1] = data[i];
    end
    if (cfg.par_en) fr_d[nd + 4'd1] = par;
    len_d = nd + 4'd2 + {3'h0, cfg.par_en} + {3'h0, cfg.stop2};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      busy <= 1'b0;
      txd <= 1'b1;
      sh_q <= 12'hFFF;
      n_q <= 4'h0;
      cnt_q <= 4'h0;
    end else if (!busy) begin
      if (start) begin
        busy <= 1'b1;
        txd <= fr_d[0];
        sh_q <= {1'b1, fr_d[11:1]};
        n_q <= len_d - 4'h1;
        cnt_q <= 4'h0;
      end
    end else if (tick) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == 4'hF) begin
        if (n_q == 4'h0) begin
          busy <= 1'b0;
          txd <= 1'b1;
        end else begin
          txd <= sh_q[0];
          sh_q <= {1'b1, sh_q[11:1]};
          n_q <= n_q - 4'h1;
        end
      end
    end
  end
endmodule

// [testbench/spf_checker.sv]
/*
  Port checker for spf_top.
  Bound to every spf_top instance; one clock domain.
*/
`timescale 1ns/1ns
module spf_checker #(
  parameter logic [31:0] IDLE_CYCLES = spf_pkg::IDLE_CYCLES
) (
  // Clock and resets
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire logic            por,
  // Register bus
  input  spf_pkg::spf_axi_req_s axi_req,
  input  spf_pkg::spf_axi_rsp_s axi_rsp,
  // Transceiver and strap
  input  wire logic            rs485_rxd,
  input  wire logic            rs485_txd,
  input  wire logic            rs485_de,
  input  wire logic            rs485_re_n,
  input  wire logic            halt_jumper
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst || por);

  re_n_tracks_a: assert property (rs485_re_n == rs485_de)
    else $error("receiver enable off driver");
  idle_high_a: assert property (!rs485_de |-> rs485_txd)
    else $error("line low undriven");
  start_driven_a: assert property ($fell(rs485_txd) |-> rs485_de)
    else $error("start bit undriven");
  stop_release_a: assert property ($fell(rs485_de) |-> $past(rs485_txd))
    else $error("driver off before stop");
  write_answer_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
    |-> ##2 axi_rsp.bvalid) else $error("late write response");
  bresp_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped");
  read_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("late read data");
  read_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped");
  decerr_read_a: assert property (axi_req.arvalid && axi_rsp.arready && axi_req.araddr > spf_pkg::ADDR_CHECK
    |=> axi_rsp.rresp == spf_pkg::RESP_DECERR && axi_rsp.rdata == 32'h0) else $error("unmapped read");

  cover property (axi_rsp.bvalid && axi_req.bready);
  cover property ($rose(rs485_de));
  cover property (axi_rsp.rvalid && axi_rsp.rresp == spf_pkg::RESP_DECERR);
endmodule

bind spf_top spf_checker #(.IDLE_CYCLES(IDLE_CYCLES)) chk_u (.clk(clk), .srst(srst), .por(por),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .rs485_rxd(rs485_rxd), .rs485_txd(rs485_txd),
  .rs485_de(rs485_de), .rs485_re_n(rs485_re_n), .halt_jumper(halt_jumper));

// [testbench/spf_host.sv]
/*
  Far-side host on the serial line, 8 data bits, even parity, one stop.
  Assumes BIT clk cycles per bit; line idles high.
*/
`timescale 1ns/1ns
module spf_host #(
  parameter int BIT = 1088
) (
  input  wire logic clk,
  output logic      rxd,
  input  wire logic txd
);
  logic [8:0] rx_last;
  int         rx_n = 0;

  initial rxd = 1'b1;

  // Host speaks the port's own format
  task automatic send(input logic [7:0] d, input logic bad);
    logic [10:0] f;
    f = {1'b1, ^d ^ bad, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask

  // Data then parity, sampled mid-bit
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge clk);
      rx_last[i] = txd;
    end
    rx_n++;
  end
endmodule

// [testbench/spf_top_bench.sv]
/*
  Self-checking bench for spf_top over AXI4-Lite and a host model.
  Assumes short idle timeout and 230400 baud.
*/
`timescale 1ns/1ns
module spf_top_bench;
  localparam logic [7:0] A_F = spf_pkg::ADDR_FORMAT;
  localparam logic [7:0] A_P = spf_pkg::ADDR_PROTO;
  localparam logic [7:0] A_R = spf_pkg::ADDR_RXDATA;
  logic                  clk = 1'b0;
  logic                  srst = 1'b1;
  logic                  por = 1'b1;
  logic                  halt_jumper = 1'b0;
  logic                  rxd;
  logic                  txd;
  logic                  de;
  logic                  re_n;
  logic [1:0]            br;
  spf_pkg::spf_axi_req_s req = '0;
  spf_pkg::spf_axi_rsp_s rsp;
  int                    mismatches = 0;
  int                    cmp_count = 0;
  logic [2:0]            md [5] = '{3'h7, 3'h1, 3'h3, 3'h2, 3'h6};

  always #2 clk = ~clk;

  spf_top #(.IDLE_CYCLES(32'h4E20)) dut_u (.clk(clk), .srst(srst), .por(por), .axi_req(req), .axi_rsp(rsp),
    .rs485_rxd(rxd), .rs485_txd(txd), .rs485_de(de), .rs485_re_n(re_n), .halt_jumper(halt_jumper));
  spf_host host_u (.clk(clk), .rxd(rxd), .txd(txd));

  task automatic ck(input logic [33:0] g, input logic [33:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: %h not %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ga;
    logic gw;
    ga = 1'b0;
    gw = 1'b0;
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= s;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    while (!(ga && gw)) begin
      @(posedge clk);
      if (rsp.awready && !ga) begin
        ga = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (rsp.wready && !gw) begin
        gw = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!rsp.bvalid);
    req.bready <= 1'b1;
    @(posedge clk);
    br = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  // Read, mask and compare with response code on top
  task automatic rk(input logic [7:0] a, input logic [31:0] m, input logic [33:0] e);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do @(posedge clk); while (!rsp.arready);
    req.arvalid <= 1'b0;
    do @(posedge clk); while (!rsp.rvalid);
    req.rready <= 1'b1;
    @(posedge clk);
    ck({rsp.rresp, rsp.rdata & m}, e);
    req.rready <= 1'b0;
  endtask

  task automatic final_report;
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    final_report;
  end

  initial begin
    repeat (5) @(posedge clk);
    por <= 1'b0;
    srst <= 1'b0;
    rk(A_F, 32'h1FF, 34'h006);
    rk(A_P, 32'h177, 34'h000);
    wr(A_F, 32'h24A, 4'h3);
    rk(A_F, 32'h1FF, 34'h006);
    wr(A_F, 32'h14A, 4'h3);
    rk(A_F, 32'h1FF, 34'h04A);
    srst <= 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rk(A_F, 32'h1FF, 34'h04A);
    host_u.send(8'h3A, 1'b0);
    rk(A_P, 32'h170, 34'h030);
    host_u.send(8'h40, 1'b0);
    repeat (18500) @(posedge clk);
    rk(A_P, 32'h170, 34'h130);
    repeat (2000) @(posedge clk);
    rk(A_P, 32'h070, 34'h000);
    rk(A_R, 32'h7FF, 34'h43A);
    rk(A_R, 32'h7FF, 34'h440);
    host_u.send(8'h2A, 1'b1);
    rk(A_P, 32'h070, 34'h000);
    rk(A_R, 32'h7FF, 34'h52A);
    rk(spf_pkg::ADDR_RXSTAT, 32'h3FF, 34'h000);
    for (int i = 0; i < 5; i++) begin
      wr(A_P, 32'(i + 1), 4'h1);
      rk(A_P, 32'h077, 34'({md[i], 1'b0, 3'(i + 1)}));
    end
    host_u.send(8'h3A, 1'b0);
    rk(A_P, 32'h077, 34'h065);
    rk(spf_pkg::ADDR_RXSTAT, 32'h3FF, 34'h001);
    rk(spf_pkg::ADDR_CHECK, 32'hFFFFFFFF, 34'h03A3A533F);
    wr(spf_pkg::ADDR_CHECK, 32'h0, 4'hF);
    rk(spf_pkg::ADDR_CHECK, 32'hFFFFFFFF, 34'h00000FFFF);
    wr(A_P, 32'h105, 4'h3);
    rk(A_P, 32'h177, 34'h065);
    wr(spf_pkg::ADDR_TX, 32'h0C4, 4'h1);
    ck(34'({de, re_n}), 34'h3);
    wait (host_u.rx_n == 1);
    ck(34'(host_u.rx_last), 34'h1C4);
    repeat (1700) @(posedge clk);
    ck(34'({de, re_n}), 34'h0);
    wr(8'h20, 32'h0, 4'hF);
    ck(34'(br), 34'h3);
    rk(8'h20, 32'hFFFFFFFF, 34'h300000000);
    halt_jumper <= 1'b1;
    por <= 1'b1;
    repeat (5) @(posedge clk);
    por <= 1'b0;
    rk(A_F, 32'h1FF, 34'h106);
    wr(A_F, 32'h14A, 4'h3);
    rk(A_F, 32'h1FF, 34'h106);
    final_report;
  end
endmodule
